/* File: include/cdps_params.svh */
// constants for the card detect and power sequencer
`ifndef CDPS_PARAMS_SVH
`define CDPS_PARAMS_SVH

`define CDPS_CLK_MHZ 200
// filter time in microseconds, between the 50 us floor and 150 us ceiling
`define CDPS_FILT_US 75
`define CDPS_FILT_CYC (`CDPS_FILT_US * `CDPS_CLK_MHZ)
`define CDPS_FILT_W 14
// step spacing of the power down order, nanoseconds
`define CDPS_STEP_NS 500
`define CDPS_CLK_NS 5
`define CDPS_STEP_CYC (`CDPS_STEP_NS / `CDPS_CLK_NS)
`define CDPS_STEP_W 7
// normally-open switch: open input reads high, meaning no card
`define CDPS_POL_RST 1'b0
// sync idle levels after reset: select and program mode high, rest low
`define CDPS_SYNC_IDLE 9'h140

`endif

/* File: include/cdps_pkg.sv */
// types for the card detect and power sequencer
package cdps_pkg;

    typedef enum logic [2:0] {
        CDPS_OFF,
        CDPS_RAMP,
        CDPS_UP_DATA,
        CDPS_UP_CLK,
        CDPS_UP_RST,
        CDPS_ACTIVE,
        CDPS_DN
    } cdps_state_t;

    typedef struct packed {
        logic supply;
        logic data_en;
        logic clk_en;
        logic rst_en;
    } cdps_card_en_t;

    typedef struct packed {
        logic card_present;
        logic insert_ev;
        logic extract_ev;
    } cdps_det_t;

endpackage

/* File: logic/cdps_filter.sv */
// detect input synchroniser and time-based debounce filter
`timescale 1ns/1ps
`default_nettype none
`include "cdps_params.svh"

module cdps_filter
    import cdps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_switch,
    input wire logic i_pol_nc,
    output cdps_det_t o_det
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [`CDPS_FILT_W-1:0] cnt;
        cdps_det_t det;
    } cdps_filt_st_t;

    cdps_filt_st_t st_r;
    cdps_filt_st_t st_nxt;
    logic present_raw;

    // open switch reads high; with normally-closed wiring high means card
    assign present_raw = i_pol_nc ? st_r.stable : ~st_r.stable;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = i_switch;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.det.insert_ev = 1'b0;
        st_nxt.det.extract_ev = 1'b0;
        if (!i_enable) begin
            st_nxt.cnt = '0;
        end else if (st_r.sync2 == st_r.stable) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt ==
                     `CDPS_FILT_W'(`CDPS_FILT_CYC - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.stable = st_r.sync2;
        end else begin
            st_nxt.cnt = st_r.cnt + `CDPS_FILT_W'(1);
        end
        // a polarity change re-evaluates presence and may itself raise events
        if (present_raw != st_r.det.card_present) begin
            st_nxt.det.card_present = present_raw;
            st_nxt.det.insert_ev = present_raw;
            st_nxt.det.extract_ev = ~present_raw;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= '{sync1: 1'b1, sync2: 1'b1, stable: 1'b1,
                      cnt: '0, det: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_det = st_r.det;

endmodule
`default_nettype wire

/* File: logic/cdps_host_sync.sv */
// two-flop synchronisers for the host pins and the battery monitor
`timescale 1ns/1ps
`default_nettype none

module cdps_host_sync #(
    parameter int W = 5
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [W-1:0] i_async,
    input wire logic [W-1:0] i_rst_val,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [1:0] prime_r;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= i_async[g];
                    s2_r[g] <= s1_r[g];
                end
            end
        end
    endgenerate

    // until both stages hold real samples the parent sees its idle levels,
    // so no false select or request edge follows reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prime_r <= 2'h0;
        end else begin
            prime_r <= {prime_r[0], 1'b1};
        end
    end

    assign o_sync = prime_r[1] ? s2_r : i_rst_val;

endmodule
`default_nettype wire

/* File: logic/cdps_top.sv */
// card detect, interrupt and card power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cdps_params.svh"

module cdps_top
    import cdps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_chip_select_n,
    input wire logic i_supply_request,
    input wire logic i_program_mode_n,
    input wire logic i_prog_pol_nc,
    input wire logic i_batt_good,
    input wire logic i_supply_at_level,
    input wire logic i_socket_switch_input,
    input wire logic i_host_data,
    input wire logic i_host_reset,
    input wire logic i_card_data_line,
    output logic o_int_n,
    output logic o_status,
    output logic o_converter_en,
    output logic o_card_supply,
    output logic o_card_clock_en,
    output logic o_card_reset_out,
    output logic o_card_data_line,
    output logic o_card_data_oe_n,
    output logic o_host_data,
    output logic o_host_data_oe_n
);

    //--------------------------------------------------------------
    // input synchronisation
    //--------------------------------------------------------------
    // bit order: cs_n, req, pgm_n, pol, batt, lvl, hdata, hrst, cdata
    localparam int NS = 9;
    logic [NS-1:0] raw;
    logic [NS-1:0] syn;
    logic cs_n;
    logic req;
    logic pgm_n;
    logic pol_in;
    logic batt;
    logic lvl;
    logic hdata;
    logic hrst;
    logic cdata;

    assign raw = {i_chip_select_n, i_supply_request, i_program_mode_n,
                  i_prog_pol_nc, i_batt_good, i_supply_at_level,
                  i_host_data, i_host_reset, i_card_data_line};
    assign {cs_n, req, pgm_n, pol_in, batt, lvl, hdata, hrst, cdata} = syn;

    cdps_host_sync #(
        .W(NS)
    ) u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_async(raw),
        // select and program-mode idle high after reset
        .i_rst_val(`CDPS_SYNC_IDLE),
        .o_sync(syn)
    );

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    typedef struct packed {
        logic cs_n_d;
        logic req_d;
        logic pgm_seen;
        logic pol_nc;
        logic por_done;
        logic int_n;
        cdps_state_t st;
        logic [`CDPS_STEP_W-1:0] step_cnt;
        cdps_card_en_t en;
        logic conv;
        logic status;
        logic card_rst;
        logic card_dat;
        logic card_oe_n;
        logic hdat;
        logic hdat_oe_n;
    } cdps_top_st_t;

    cdps_top_st_t s_r;
    cdps_top_st_t s_nxt;
    cdps_det_t det;
    logic cs_rise;
    logic req_rise;
    logic pd_req;
    logic step_done;

    cdps_filter u_filter (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_enable(s_r.por_done),
        .i_switch(i_socket_switch_input),
        .i_pol_nc(s_r.pol_nc),
        .o_det(det)
    );

    // select is seen three clocks late; a pulse under one clock may be lost
    assign cs_rise = cs_n & ~s_r.cs_n_d;
    assign req_rise = req & ~s_r.req_d;
    // host request low with select low, extraction, or battery fault
    assign pd_req = (~req & ~cs_n) | det.extract_ev | ~batt;
    assign step_done = (s_r.step_cnt ==
                        `CDPS_STEP_W'(`CDPS_STEP_CYC - 1));

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.cs_n_d = cs_n;
        s_nxt.req_d = req;
        s_nxt.step_cnt = '0;
        s_nxt.status = s_r.por_done ? det.card_present : 1'b0;

        //----------------------------------------------------------
        // power-on reset
        //----------------------------------------------------------
        // internal power-on reset: defaults restored while battery low
        if (!batt) begin
            s_nxt.por_done = 1'b0;
            s_nxt.pol_nc = `CDPS_POL_RST;
            s_nxt.int_n = 1'b1;
        end else begin
            s_nxt.por_done = 1'b1;
        end

        //----------------------------------------------------------
        // programming latch
        //----------------------------------------------------------
        // programming window opens on select low with program mode low
        if (!cs_n && !pgm_n) begin
            s_nxt.pgm_seen = 1'b1;
        end
        if (cs_rise) begin
            s_nxt.pgm_seen = 1'b0;
            if (s_r.pgm_seen && batt) begin
                s_nxt.pol_nc = pol_in;
            end
        end

        //----------------------------------------------------------
        // interrupt
        //----------------------------------------------------------
        // interrupt: release first, then any new event wins
        if (cs_rise || (req_rise && !cs_n)) begin
            s_nxt.int_n = 1'b1;
        end
        if (s_r.por_done && (det.insert_ev || det.extract_ev)) begin
            s_nxt.int_n = 1'b0;
        end

        //----------------------------------------------------------
        // card sequencer
        //----------------------------------------------------------
        case (s_r.st)
            CDPS_OFF: begin
                // standby: converter idle, every card line at ground
                s_nxt.en = '0;
                s_nxt.conv = 1'b0;
                if (s_r.por_done && batt && req && !cs_n) begin
                    s_nxt.st = CDPS_RAMP;
                    s_nxt.conv = 1'b1;
                end
            end
            CDPS_RAMP: begin
                // all card lines stay low until supply is good
                s_nxt.en = '0;
                if (pd_req) begin
                    s_nxt.st = CDPS_DN;
                end else if (lvl) begin
                    s_nxt.en.supply = 1'b1;
                    s_nxt.st = CDPS_UP_DATA;
                end
            end
            CDPS_UP_DATA, CDPS_UP_CLK, CDPS_UP_RST: begin
                s_nxt.step_cnt = s_r.step_cnt + `CDPS_STEP_W'(1);
                if (pd_req) begin
                    s_nxt.st = CDPS_DN;
                    s_nxt.step_cnt = '0;
                end else if (step_done) begin
                    s_nxt.step_cnt = '0;
                    if (s_r.st == CDPS_UP_DATA) begin
                        s_nxt.en.data_en = 1'b1;
                        s_nxt.st = CDPS_UP_CLK;
                    end else if (s_r.st == CDPS_UP_CLK) begin
                        s_nxt.en.clk_en = 1'b1;
                        s_nxt.st = CDPS_UP_RST;
                    end else begin
                        s_nxt.en.rst_en = 1'b1;
                        s_nxt.st = CDPS_ACTIVE;
                    end
                end
            end
            CDPS_ACTIVE: begin
                // select may go high freely; only a request with select low, extraction or battery fault drops power
                if (pd_req) begin
                    s_nxt.st = CDPS_DN;
                end
            end
            CDPS_DN: begin
                s_nxt.step_cnt = s_r.step_cnt + `CDPS_STEP_W'(1);
                if (step_done) begin
                    s_nxt.step_cnt = '0;
                    // drop reset, clock, data, then supply
                    // stages that never came up are skipped without a step
                    if (s_r.en.rst_en) begin
                        s_nxt.en.rst_en = 1'b0;
                    end else if (s_r.en.clk_en) begin
                        s_nxt.en.clk_en = 1'b0;
                    end else if (s_r.en.data_en) begin
                        s_nxt.en.data_en = 1'b0;
                    end else begin
                        s_nxt.en.supply = 1'b0;
                        s_nxt.conv = 1'b0;
                        s_nxt.st = CDPS_OFF;
                    end
                end
            end
            default: begin
                s_nxt.st = CDPS_OFF;
                s_nxt.en = '0;
            end
        endcase

        //----------------------------------------------------------
        // card and host lines
        //----------------------------------------------------------
        // card lines follow the host only once their stage is enabled
        s_nxt.card_rst = s_nxt.en.rst_en & hrst;
        s_nxt.card_dat = s_nxt.en.data_en & hdata;
        // open-drain style data: drive low or release to pull-up
        s_nxt.card_oe_n = ~(s_nxt.en.supply & ~s_nxt.card_dat);
        // host line: only driven while selected and card data active
        // returned card data lags the card pin by three clocks
        s_nxt.hdat = cdata;
        s_nxt.hdat_oe_n = cs_n | ~s_nxt.en.data_en;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r <= '{cs_n_d: 1'b1, req_d: 1'b0, pgm_seen: 1'b0,
                     pol_nc: `CDPS_POL_RST, por_done: 1'b0, int_n: 1'b1,
                     st: CDPS_OFF, step_cnt: '0, en: '0, conv: 1'b0,
                     status: 1'b0, card_rst: 1'b0, card_dat: 1'b0,
                     card_oe_n: 1'b1, hdat: 1'b0, hdat_oe_n: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign o_int_n = s_r.int_n;
    assign o_status = s_r.status;
    assign o_converter_en = s_r.conv;
    assign o_card_supply = s_r.en.supply;
    assign o_card_clock_en = s_r.en.clk_en;
    assign o_card_reset_out = s_r.card_rst;
    assign o_card_data_line = s_r.card_dat;
    assign o_card_data_oe_n = s_r.card_oe_n;
    assign o_host_data = s_r.hdat;
    assign o_host_data_oe_n = s_r.hdat_oe_n;

endmodule
`default_nettype wire

/* File: verif/cdps_host_model.sv */
// host controller model: select, supply request and programming pins
`timescale 1ns/1ps
`default_nettype none

module cdps_host_model #(
    // settling wait, shortened from about 3 ms to keep the run short
    parameter int SETTLE_CYC = 200
) (
    input wire logic i_clk,
    input wire logic i_status,
    output logic o_cs_n,
    output logic o_req,
    output logic o_pgm_n,
    output logic o_pol_nc
);
    initial begin
        o_cs_n = 1'b1;
        o_req = 1'b0;
        o_pgm_n = 1'b1;
        o_pol_nc = 1'b0;
    end

    // select pulse, 400 cycles is the 2 us minimum
    task automatic cs_pulse(input logic program_mode_n, input logic pol);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_pgm_n <= program_mode_n;
        o_pol_nc <= pol;
        repeat (400) @(posedge i_clk);
        o_cs_n <= 1'b1;
        @(posedge i_clk);
        o_pgm_n <= 1'b1;
    endtask

    // supply is only asked for with a card reported present
    task automatic req(input logic v);
        if (v && i_status !== 1'b1) begin
            return;
        end
        if (v) begin
            repeat (SETTLE_CYC) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_req <= v;
        repeat (400) @(posedge i_clk);
        o_cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: verif/cdps_props.sv */
// port assertions for the card detect and power sequencer
`timescale 1ns/1ps
`default_nettype none

module cdps_props (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_chip_select_n,
    input wire logic i_supply_request,
    input wire logic i_program_mode_n,
    input wire logic i_prog_pol_nc,
    input wire logic i_batt_good,
    input wire logic i_supply_at_level,
    input wire logic i_socket_switch_input,
    input wire logic i_host_data,
    input wire logic i_host_reset,
    input wire logic i_card_data_line,
    input wire logic o_int_n,
    input wire logic o_status,
    input wire logic o_converter_en,
    input wire logic o_card_supply,
    input wire logic o_card_clock_en,
    input wire logic o_card_reset_out,
    input wire logic o_card_data_line,
    input wire logic o_card_data_oe_n,
    input wire logic o_host_data,
    input wire logic o_host_data_oe_n
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // ----
    // checks
    // ----
    // select passes two flops, so allow three edges before the release
    a_select_hiz: assert property (i_chip_select_n
        && $past(i_chip_select_n) && $past(i_chip_select_n, 2)
        && $past(i_chip_select_n, 3) |-> o_host_data_oe_n)
        else $error("data not released");
    a_int_release: assert property ($rose(i_chip_select_n)
        |-> ##[1:6] o_int_n) else $error("interrupt not released");
    a_clk_after_sup: assert property ($rose(o_card_clock_en)
        |-> $past(o_card_supply, 150)) else $error("clock early");
    a_rst_needs_clk: assert property (o_card_reset_out
        |-> o_card_clock_en) else $error("reset without clock");
    a_sup_at_level: assert property ($rose(o_card_supply)
        |-> $past(i_supply_at_level, 2) && o_converter_en)
        else $error("supply before level");
    a_rst_before_clk: assert property ($fell(o_card_clock_en)
        |-> !$past(o_card_reset_out, 50)) else $error("clock fell first");
    a_down_spacing: assert property ($fell(o_card_clock_en)
        && i_batt_good |-> ##[199:201] $fell(o_card_supply))
        else $error("supply step spacing");
    a_sup_conv: assert property (o_card_supply
        |-> o_converter_en) else $error("supply without converter");
    a_standby_gnd: assert property (!o_converter_en
        |-> !o_card_clock_en && !o_card_reset_out)
        else $error("standby outputs");
    // status is registered one clock after the internal reset drops
    a_batt_status: assert property (!i_batt_good
        && !$past(i_batt_good) && !$past(i_batt_good, 2)
        && !$past(i_batt_good, 3) && !$past(i_batt_good, 4)
        |-> !o_status) else $error("status with battery low");
    c_int: cover property ($fell(o_int_n));
    c_active: cover property ($rose(o_card_reset_out));
    c_down: cover property ($fell(o_card_supply));
endmodule

bind cdps_top cdps_props u_props (.i_clk, .i_arst_n, .i_chip_select_n,
    .i_supply_request, .i_program_mode_n, .i_prog_pol_nc, .i_batt_good,
    .i_supply_at_level, .i_socket_switch_input, .i_host_data, .i_host_reset,
    .i_card_data_line, .o_int_n, .o_status, .o_converter_en, .o_card_supply,
    .o_card_clock_en, .o_card_reset_out, .o_card_data_line,
    .o_card_data_oe_n, .o_host_data, .o_host_data_oe_n);
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the card detect and power sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_batt_good = 1'b0;
    logic i_supply_at_level = 1'b0;
    logic i_socket_switch_input = 1'b1;
    logic i_host_data;
    logic i_host_reset;
    logic i_card_data_line;
    logic i_chip_select_n, i_supply_request, i_program_mode_n, i_prog_pol_nc;
    logic o_int_n, o_status, o_converter_en, o_card_supply, o_card_clock_en;
    logic o_card_reset_out, o_card_data_line, o_card_data_oe_n;
    logic o_host_data, o_host_data_oe_n;
    int errors = 0;
    int samples_checked = 0;
    int n;
    wire [3:0] mon = {o_int_n, o_card_supply, o_card_clock_en,
        o_card_reset_out};
    localparam int INT = 3, SUP = 2, CKE = 1, RST = 0;

    always #2.5 i_clk = ~i_clk;

    cdps_host_model host (.i_clk, .i_status(o_status),
        .o_cs_n(i_chip_select_n), .o_req(i_supply_request),
        .o_pgm_n(i_program_mode_n), .o_pol_nc(i_prog_pol_nc));

    cdps_top uut (.i_clk, .i_arst_n, .i_chip_select_n, .i_supply_request,
        .i_program_mode_n, .i_prog_pol_nc, .i_batt_good, .i_supply_at_level,
        .i_socket_switch_input, .i_host_data, .i_host_reset,
        .i_card_data_line, .o_int_n, .o_status, .o_converter_en,
        .o_card_supply, .o_card_clock_en, .o_card_reset_out,
        .o_card_data_line, .o_card_data_oe_n, .o_host_data,
        .o_host_data_oe_n);

    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask

    // counts settled cycles until the watched output reads v
    task automatic wait_for(input int idx, input logic v, input int lim);
        n = 0;
        while (mon[idx] !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk(mon[idx] === v, "wait timed out");
    endtask

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_reset();
        @(posedge i_clk);
        i_host_data <= 1'b1;
        i_host_reset <= 1'b1;
        i_card_data_line <= 1'b1;
        cyc(2);
        chk(o_int_n === 1'b1 && o_card_supply === 1'b0, "reset int");
        chk(o_host_data_oe_n === 1'b1 && o_status === 1'b0, "reset");
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        i_batt_good <= 1'b1;
        cyc(20);
        chk(o_status === 1'b0 && o_int_n === 1'b1, "open is empty");
        chk(o_converter_en === 1'b0, "standby");
    endtask

    task automatic t_glitch();
        @(posedge i_clk);
        i_socket_switch_input <= 1'b0;
        repeat (8000) @(posedge i_clk);
        i_socket_switch_input <= 1'b1;
        cyc(200);
        chk(o_int_n === 1'b1 && o_status === 1'b0, "short pulse");
    endtask

    task automatic t_insert();
        @(posedge i_clk);
        i_socket_switch_input <= 1'b0;
        wait_for(INT, 1'b0, 16000);
        chk(n >= 15000 && n <= 15020, "filter time");
        chk(o_status === 1'b1, "card present");
        host.req(1'b1);
        chk(o_int_n === 1'b1, "request clears");
        chk(o_converter_en === 1'b1, "converter on");
        chk(o_card_supply === 1'b0, "held in ramp");
        @(posedge i_clk);
        i_supply_at_level <= 1'b1;
        wait_for(SUP, 1'b1, 20);
        wait_for(CKE, 1'b1, 300);
        chk(n >= 199 && n <= 201, "clock step");
        wait_for(RST, 1'b1, 300);
        chk(n >= 99 && n <= 101, "reset step");
        @(posedge i_clk);
        i_host_reset <= 1'b0;
        i_host_data <= 1'b0;
        cyc(6);
        chk(o_card_reset_out === 1'b0, "reset follows");
        chk(o_card_data_oe_n === 1'b0 && !o_card_data_line, "data");
        chk(o_card_supply === 1'b1, "kept on");
        @(posedge i_clk);
        i_host_reset <= 1'b1;
        i_host_data <= 1'b1;
        cyc(6);
        // select while active: card data returns to the host
        fork
            host.cs_pulse(1'b1, 1'b0);
            begin
                cyc(20);
                chk(o_host_data_oe_n === 1'b0, "host data driven");
                chk(o_host_data === 1'b1, "card data high");
                @(posedge i_clk);
                i_card_data_line <= 1'b0;
                cyc(6);
                chk(o_host_data === 1'b0, "card data low");
                @(posedge i_clk);
                i_card_data_line <= 1'b1;
            end
        join
        cyc(6);
        chk(o_host_data_oe_n === 1'b1, "host data released");
    endtask

    task automatic t_hostdown();
        fork
            host.req(1'b0);
            begin
                wait_for(RST, 1'b0, 130);
                wait_for(CKE, 1'b0, 120);
                chk(n >= 99 && n <= 101, "clock after reset");
                wait_for(SUP, 1'b0, 220);
                chk(n >= 199 && n <= 201, "supply last");
            end
        join
        chk(o_converter_en === 1'b0, "converter off");
    endtask

    task automatic t_extract();
        host.req(1'b1);
        wait_for(RST, 1'b1, 400);
        @(posedge i_clk);
        i_socket_switch_input <= 1'b1;
        wait_for(INT, 1'b0, 16000);
        wait_for(SUP, 1'b0, 420);
        host.cs_pulse(1'b1, 1'b0);
        cyc(6);
        chk(o_int_n === 1'b1, "select clears");
        host.req(1'b0);
    endtask

    task automatic t_polarity();
        host.cs_pulse(1'b0, 1'b1);
        wait_for(INT, 1'b0, 15100);
        chk(o_status === 1'b1, "closed switch");
        host.cs_pulse(1'b1, 1'b0);
    endtask

    task automatic t_abort();
        @(posedge i_clk);
        i_supply_at_level <= 1'b0;
        host.req(1'b1);
        host.req(1'b0);
        cyc(40);
        chk(o_converter_en === 1'b0 && !o_card_supply, "abort");
    endtask

    task automatic t_batt();
        @(posedge i_clk);
        i_supply_at_level <= 1'b1;
        host.req(1'b1);
        wait_for(RST, 1'b1, 400);
        @(posedge i_clk);
        i_batt_good <= 1'b0;
        wait_for(SUP, 1'b0, 420);
        chk(o_status === 1'b0 && o_converter_en === 1'b0, "no op");
    endtask

    initial begin
        t_reset();
        t_glitch();
        t_insert();
        t_hostdown();
        t_extract();
        t_polarity();
        t_abort();
        t_batt();
        print_verdict();
    end

    // whole sequence needs about 225 us
    initial begin
        #450000;
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
